// [rtl/sec_erase_host.sv]
// host controller issuing sector erase and polling completion status
// assumes one flash device on the pins, reads answered within the strobe time
`timescale 1ns/1ps
`default_nettype none
module sec_erase_host (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // user orders
    input wire logic go,
    input wire logic [7:0] sector_mask,
    output logic busy_ff,
    output var sec_pkg::sec_result_s result_ff,
    output logic window_closed_ff,
    // flash pins
    output logic [16:0] addr,
    output logic ce_b,
    output logic we_b,
    output logic oe_b,
    output logic [7:0] dq_out,
    output logic dq_oe,
    input wire logic [7:0] dq_in
);
    typedef enum logic [3:0] {
        S_IDLE, S_SEQ, S_EXTRA, S_POLL1, S_POLL2, S_RECHECK, S_RESET, S_FINAL
    } sec_state_e;

    sec_state_e state_ff, nxt_state;
    logic [2:0] step_ff, nxt_step;
    logic [2:0] first_ff, nxt_first;
    logic [7:0] pend_ff, nxt_pend;
    logic [7:0] prev_ff, nxt_prev;
    logic [31:0] gap_ff;
    logic bus_busy, bus_done;
    logic [7:0] rdata;
    logic start;
    sec_pkg::sec_cycle_s req;
    sec_pkg::sec_result_s nxt_result;
    logic is_write_done;
    assign is_write_done = state_ff == S_SEQ || state_ff == S_EXTRA || state_ff == S_RESET;

    function automatic sec_pkg::sec_cycle_s wr(input logic [16:0] a, input logic [7:0] d);
        wr = '{addr: a, data: d, write: 1'b1};
    endfunction

    function automatic logic [2:0] lowest(input logic [7:0] m);
        lowest = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                lowest = 3'(i);
            end
        end
    endfunction

    wire [2:0] next_sector = lowest(pend_ff);
    wire toggled = rdata[sec_pkg::TOGGLE_POS] != prev_ff[sec_pkg::TOGGLE_POS];
    wire timeout_seen = rdata[sec_pkg::TIMEOUT_POS];
    wire gap_ok = gap_ff < 32'(sec_pkg::GAP_CYC);

    sec_pkg::sec_cycle_s seq_cycle;
    always_comb begin
        case (step_ff)
            3'h0: seq_cycle = wr(sec_pkg::UNLOCK_A1, sec_pkg::UNLOCK_D1);
            3'h1: seq_cycle = wr(sec_pkg::UNLOCK_A2, sec_pkg::UNLOCK_D2);
            3'h2: seq_cycle = wr(sec_pkg::UNLOCK_A1, sec_pkg::ERASE_SETUP);
            3'h3: seq_cycle = wr(sec_pkg::UNLOCK_A1, sec_pkg::UNLOCK_D1);
            3'h4: seq_cycle = wr(sec_pkg::UNLOCK_A2, sec_pkg::UNLOCK_D2);
            default: seq_cycle = wr(sec_pkg::sec_addr(first_ff), sec_pkg::SECTOR_ERASE);
        endcase
    end

    wire [2:0] rst_step = (step_ff > 3'h2) ? 3'h2 : step_ff;
    sec_pkg::sec_cycle_s rst_cycle;
    always_comb begin
        case (rst_step)
            3'h0: rst_cycle = wr(sec_pkg::UNLOCK_A1, sec_pkg::UNLOCK_D1);
            3'h1: rst_cycle = wr(sec_pkg::UNLOCK_A2, sec_pkg::UNLOCK_D2);
            default: rst_cycle = wr(sec_pkg::UNLOCK_A1, sec_pkg::RESET_CMD);
        endcase
    end

    // polling reads at the first chosen sector, a valid poll address
    wire sec_pkg::sec_cycle_s poll_cycle = '{addr: sec_pkg::sec_addr(first_ff),
                                             data: 8'h00, write: 1'b0};

    always_comb begin
        nxt_state = state_ff;
        nxt_step = step_ff;
        nxt_first = first_ff;
        nxt_pend = pend_ff;
        nxt_prev = prev_ff;
        nxt_result = '{done: 1'b0, ok: result_ff.ok, failed: result_ff.failed};
        start = 1'b0;
        req = poll_cycle;
        case (state_ff)
            S_IDLE: begin
                if (go && sector_mask != 8'h00) begin
                    nxt_first = lowest(sector_mask);
                    nxt_pend = sector_mask & ~(8'h01 << lowest(sector_mask));
                    nxt_step = 3'h0;
                    nxt_result = '{done: 1'b0, ok: 1'b0, failed: 1'b0};
                    nxt_state = S_SEQ;
                end
            end
            S_SEQ: begin
                req = seq_cycle;
                start = !bus_busy;
                if (bus_done) begin
                    if (step_ff == 3'h5) begin
                        nxt_state = (pend_ff != 8'h00) ? S_EXTRA : S_POLL1;
                    end else begin
                        nxt_step = step_ff + 3'h1;
                    end
                end
            end
            S_EXTRA: begin
                // one sector command each, spacing kept by back to back writes
                req = wr(sec_pkg::sec_addr(next_sector), sec_pkg::SECTOR_ERASE);
                start = !bus_busy && gap_ok;
                if (bus_done) begin
                    nxt_pend = pend_ff & ~(8'h01 << next_sector);
                    if ((pend_ff & ~(8'h01 << next_sector)) == 8'h00) begin
                        nxt_state = S_POLL1;
                    end
                end else if (!bus_busy && !gap_ok) begin
                    // window lapsed: abort, report failure and return to idle
                    nxt_result = '{done: 1'b1, ok: 1'b0, failed: 1'b1};
                    nxt_state = S_IDLE;
                end
            end
            S_POLL1: begin
                start = !bus_busy;
                if (bus_done) begin
                    nxt_prev = rdata;
                    nxt_state = S_POLL2;
                end
            end
            S_POLL2, S_RECHECK: begin
                start = !bus_busy;
                if (bus_done) begin
                    nxt_prev = rdata;
                    if (!toggled) begin
                        nxt_result = '{done: 1'b1, ok: 1'b1, failed: 1'b0};
                        nxt_state = S_FINAL;
                    end else if (state_ff == S_RECHECK) begin
                        nxt_step = 3'h0;
                        nxt_state = S_RESET;
                    end else if (timeout_seen) begin
                        nxt_state = S_RECHECK;
                    end
                end
            end
            S_RESET: begin
                req = rst_cycle;
                start = !bus_busy;
                if (bus_done) begin
                    if (rst_step == 3'h2) begin
                        nxt_result = '{done: 1'b1, ok: 1'b0, failed: 1'b1};
                        nxt_state = S_IDLE;
                    end else begin
                        nxt_step = step_ff + 3'h1;
                    end
                end
            end
            S_FINAL: begin
                // one more read so every data bit is settled
                start = !bus_busy;
                if (bus_done) begin
                    nxt_state = S_IDLE;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= S_IDLE;
            step_ff <= 3'h0;
            first_ff <= 3'h0;
            pend_ff <= 8'h00;
            prev_ff <= 8'h00;
            result_ff <= '{done: 1'b0, ok: 1'b0, failed: 1'b0};
            busy_ff <= 1'b0;
            window_closed_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            step_ff <= nxt_step;
            first_ff <= nxt_first;
            pend_ff <= nxt_pend;
            prev_ff <= nxt_prev;
            result_ff <= nxt_result;
            busy_ff <= nxt_state != S_IDLE;
            if (bus_done && !is_write_done) begin
                window_closed_ff <= rdata[sec_pkg::WINDOW_POS];
            end
        end
    end

    // spacing since the done clock of the last write cycle, one clock after its strobe rose
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_ff <= 32'h0;
        end else if (bus_done && is_write_done) begin
            gap_ff <= 32'h0;
        end else if (gap_ff != 32'hFFFFFFFF) begin
            gap_ff <= gap_ff + 32'h1;
        end
    end

    sec_bus_cycle u_bus (
        .clk(clk),
        .rst_b(rst_b),
        .start(start),
        .req(req),
        .busy(bus_busy),
        .done_ff(bus_done),
        .rdata_ff(rdata),
        .addr_ff(addr),
        .ce_b_ff(ce_b),
        .we_b_ff(we_b),
        .oe_b_ff(oe_b),
        .dq_out_ff(dq_out),
        .dq_oe_ff(dq_oe),
        .dq_in(dq_in)
    );
endmodule
`default_nettype wire

// [rtl/sec_pkg.sv]
// constants and carriers for the sector erase host controller
// assumes a byte-wide parallel flash on chip-select, write and output strobes
// Behaviour
// - sector erase is six write cycles
// - unlock, unlock, setup, unlock, unlock, sector command
// - extra sector writes spaced under fifty microseconds
// - host should mask interrupts while queuing
// - other write in window aborts, restart sequence
// - erase-window bit may be skipped if fast
// - polling valid after final strobe, valid address
// - erase polling zero then one, poll sector
// - reread after polling bit turns true
// - recheck polling bit when timeout bit set; code rechecks the toggle bit instead and never reads the polling bit
// - toggle check needs two reads in row
// - timeout set: retest toggle, still toggling fails
// - resuming polling restarts toggle check
// - after timeout, write reset command sequence
package sec_pkg;
    localparam int CLK_MHZ = 50;
    localparam int WINDOW_US = 50;
    // margin under the window, a fifth of it
    localparam int GAP_US = 40;
    localparam int GAP_CYC = GAP_US * CLK_MHZ;
    localparam int STROBE_CYC = 4;
    localparam logic [16:0] UNLOCK_A1 = 17'h05555;
    localparam logic [16:0] UNLOCK_A2 = 17'h02AAA;
    localparam logic [7:0] UNLOCK_D1 = 8'hAA;
    localparam logic [7:0] UNLOCK_D2 = 8'h55;
    localparam logic [7:0] ERASE_SETUP = 8'h80;
    localparam logic [7:0] SECTOR_ERASE = 8'h30;
    localparam logic [7:0] RESET_CMD = 8'hF0;
    localparam int SECTOR_MSB = 16;
    localparam int SECTOR_LSB = 14;
    localparam int DATA_POLLING_POS = 7;
    localparam int TOGGLE_POS = 6;
    localparam int TIMEOUT_POS = 5;
    localparam int WINDOW_POS = 3;

    typedef struct packed {
        logic [16:0] addr;
        logic [7:0] data;
        logic write;
    } sec_cycle_s;

    typedef struct packed {
        logic done;
        logic ok;
        logic failed;
    } sec_result_s;

    function automatic logic [16:0] sec_addr(input logic [2:0] sector);
        sec_addr = {sector, 14'h0000};
    endfunction
endpackage

// [rtl/sec_bus_cycle.sv]
// one read or write cycle on the flash pins
// assumes the flash meets its timing within STROBE_CYC clocks
`timescale 1ns/1ps
`default_nettype none
module sec_bus_cycle (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // request
    input wire logic start,
    input var sec_pkg::sec_cycle_s req,
    output logic busy,
    output logic done_ff,
    output logic [7:0] rdata_ff,
    // flash pins
    output logic [16:0] addr_ff,
    output logic ce_b_ff,
    output logic we_b_ff,
    output logic oe_b_ff,
    output logic [7:0] dq_out_ff,
    output logic dq_oe_ff,
    input wire logic [7:0] dq_in
);
    logic [3:0] cnt_ff;
    logic is_wr_ff;
    wire last = busy && cnt_ff == 4'h1;
    // no new cycle in the done clock: the caller's request is still the old one then
    wire take = start && !busy && !done_ff;
    assign busy = cnt_ff != 4'h0;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 4'h0;
            is_wr_ff <= 1'b0;
            done_ff <= 1'b0;
            rdata_ff <= 8'h00;
            addr_ff <= 17'h00000;
            ce_b_ff <= 1'b1;
            we_b_ff <= 1'b1;
            oe_b_ff <= 1'b1;
            dq_out_ff <= 8'h00;
            dq_oe_ff <= 1'b0;
        end else begin
            done_ff <= last;
            if (take) begin
                cnt_ff <= 4'(sec_pkg::STROBE_CYC + 1);
                is_wr_ff <= req.write;
                addr_ff <= req.addr;
                dq_out_ff <= req.data;
                dq_oe_ff <= req.write;
                ce_b_ff <= 1'b0;
                we_b_ff <= !req.write;
                oe_b_ff <= req.write;
            end else if (busy) begin
                cnt_ff <= cnt_ff - 4'h1;
                // strobes rise one clock before data is released
                if (cnt_ff == 4'h2) begin
                    we_b_ff <= 1'b1;
                    oe_b_ff <= 1'b1;
                    ce_b_ff <= 1'b1;
                    if (!is_wr_ff) begin
                        rdata_ff <= dq_in;
                    end
                end
                if (last) begin
                    dq_oe_ff <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [tb/sec_erase_host_assertions.sv]
// pin-level checks on the sector erase host
// assumes binding onto sec_erase_host, one clock domain
`timescale 1ns/1ps
`default_nettype none
module sec_erase_host_assertions (
    // clock, reset, user side
    input wire logic clk,
    input wire logic rst_b,
    input wire logic go,
    input wire logic [7:0] sector_mask,
    input wire logic busy_ff,
    input var sec_pkg::sec_result_s result_ff,
    input wire logic window_closed_ff,
    // flash pins
    input wire logic [16:0] addr,
    input wire logic ce_b,
    input wire logic we_b,
    input wire logic oe_b,
    input wire logic [7:0] dq_out,
    input wire logic dq_oe,
    input wire logic [7:0] dq_in
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_pulse(sig);
        (!sig)[*4] ##1 sig;
    endsequence
    sequence s_unlock;
        !ce_b && !we_b && dq_oe && addr == sec_pkg::UNLOCK_A1 && dq_out == sec_pkg::UNLOCK_D1;
    endsequence
    a_write_width: assert property ($fell(we_b) |-> s_pulse(we_b))
        else $error("write strobe width wrong");
    a_read_width: assert property ($fell(oe_b) |-> s_pulse(oe_b))
        else $error("read strobe width wrong");
    a_go_unlock: assert property (go && !busy_ff && sector_mask != 8'h00 |=> ##1 s_unlock)
        else $error("first unlock write missing");
    a_zero_refused: assert property (go && !busy_ff && sector_mask == 8'h00 |=> we_b && !busy_ff)
        else $error("empty mask started a cycle");
    a_write_stable: assert property (!we_b && $past(we_b) == 1'b0 |-> $stable(addr) && $stable(dq_out) && dq_oe)
        else $error("write data moved under strobe");
    a_data_release: assert property ($rose(we_b) |=> !dq_oe)
        else $error("data bus held after write");
    a_read_no_drive: assert property (!oe_b |-> !dq_oe && we_b)
        else $error("host drives data during read");
    a_done_pulse: assert property (result_ff.done |=> !result_ff.done)
        else $error("done longer than one cycle");
    a_verdict_excl: assert property (result_ff.done |-> (result_ff.ok ^ result_ff.failed) && we_b && oe_b)
        else $error("verdict not exclusive");
endmodule
bind sec_erase_host sec_erase_host_assertions chk (.clk(clk), .rst_b(rst_b), .go(go),
    .sector_mask(sector_mask), .busy_ff(busy_ff), .result_ff(result_ff),
    .window_closed_ff(window_closed_ff), .addr(addr), .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
`default_nettype wire

// [tb/sec_flash_model.sv]
// behavioural byte-wide flash: sector erase, window, status bits
// assumes host strobes are registered to clk; no pull on the data bus
`timescale 1ns/1ps
`default_nettype none
module sec_flash_model #(
    parameter int WINDOW_CYC = 2500,
    parameter int ERASE_CYC = 300,
    parameter logic [7:0] PROTECT = 8'h40
) (
    // clock and reset of the bench
    input wire logic clk,
    input wire logic rst_b,
    // flash pins
    input wire logic [16:0] addr,
    input wire logic ce_b,
    input wire logic we_b,
    input wire logic oe_b,
    input wire logic [7:0] dq_out,
    output logic [7:0] dq_in,
    // bench controls
    input wire logic fail_mode,
    output logic [7:0] erased_ff
);
    logic [1:0] mode_ff; // 0 array, 1 window, 2 erase, 3 timed out
    logic [2:0] step_ff;
    logic [31:0] cnt_ff;
    logic [7:0] queue_ff, rel_ff, lat_d;
    logic [16:0] lat_a;
    logic we_prev, oe_prev, tog_ff;
    wire wr = !we_prev && we_b;
    wire [7:0] sel = 8'h01 << lat_a[16:14];
    wire [7:0] want_d = (mode_ff == 2'd3 && step_ff == 3'd2) ? 8'hF0 :
        (step_ff == 3'd2) ? 8'h80 : (step_ff == 3'd5) ? 8'h30 :
        (step_ff == 3'd0 || step_ff == 3'd3) ? 8'hAA : 8'h55;
    wire [14:0] want_a = (step_ff == 3'd1 || step_ff == 3'd4) ? 15'h2AAA : 15'h5555;
    wire hit = lat_d == want_d && (step_ff == 3'd5 || lat_a[14:0] == want_a);
    // released bus shows a moving pattern, never the last byte
    assign dq_in = (oe_b || ce_b) ? rel_ff : (mode_ff == 2'd0) ? 8'hFF :
        {1'b0, tog_ff, mode_ff == 2'd3, 1'b0, mode_ff != 2'd1, 3'b000};
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {mode_ff, step_ff, tog_ff, queue_ff, erased_ff, cnt_ff} <= '0;
            {we_prev, oe_prev, rel_ff} <= 10'h35A;
        end else begin
            {we_prev, oe_prev} <= {we_b, oe_b};
            rel_ff <= rel_ff + 8'h5B;
            cnt_ff <= cnt_ff + 1;
            if (!we_b) {lat_a, lat_d} <= {addr, dq_out};
            if (oe_prev && !oe_b && mode_ff != 2'd0) tog_ff <= !tog_ff;
            if ((mode_ff == 2'd0 || mode_ff == 2'd3) && wr) begin
                step_ff <= hit ? step_ff + 3'd1 : 3'd0;
                if (hit && mode_ff == 2'd3 && step_ff == 3'd2) {mode_ff, step_ff} <= 5'd0;
                if (hit && step_ff == 3'd5) begin
                    {mode_ff, step_ff, queue_ff, cnt_ff} <= {2'd1, 3'd0, sel, 32'd0};
                end
            end else if (mode_ff == 2'd1 && wr) begin
                if (lat_d == 8'h30) {queue_ff, cnt_ff} <= {queue_ff | sel, 32'd0};
                else mode_ff <= 2'd0;
            end else if (mode_ff == 2'd1 && cnt_ff == WINDOW_CYC) begin
                {mode_ff, cnt_ff} <= {2'd2, 32'd0};
            end else if (mode_ff == 2'd2 && cnt_ff == ERASE_CYC) begin
                mode_ff <= fail_mode ? 2'd3 : 2'd0;
                // protected sectors stay as they were; all protected erases nothing
                if (!fail_mode) erased_ff <= queue_ff & ~PROTECT;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for sec_erase_host against the flash model
// assumes 50 MHz clock; writes and verdicts checked from expectation queues
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 0, rst_b = 0, go = 0, fail_mode = 0, we_last = 1;
    logic [7:0] sector_mask = 8'h00, m, last_ok = 8'h00;
    logic busy_ff, window_closed_ff, ce_b, we_b, oe_b, dq_oe;
    sec_pkg::sec_result_s result_ff;
    logic [16:0] addr;
    logic [7:0] dq_out, dq_in, erased;
    logic [25:0] wr_q[$];
    logic [9:0] res_q[$];
    int error_cnt = 0, n_compared = 0;
    integer seed = 32'hb05a;
    // one protected sector in the model
    localparam logic [7:0] PROT = 8'h40;
    always #10 clk = ~clk;
    sec_erase_host uut (.clk(clk), .rst_b(rst_b), .go(go), .sector_mask(sector_mask),
        .busy_ff(busy_ff), .result_ff(result_ff), .window_closed_ff(window_closed_ff),
        .addr(addr), .ce_b(ce_b), .we_b(we_b), .oe_b(oe_b), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in));
    sec_flash_model #(.PROTECT(PROT)) flash (.clk(clk), .rst_b(rst_b), .addr(addr), .ce_b(ce_b),
        .we_b(we_b),
        .oe_b(oe_b), .dq_out(dq_out), .dq_in(dq_in), .fail_mode(fail_mode), .erased_ff(erased));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic note_wr(input logic [16:0] a, input logic [7:0] d);
        wr_q.push_back({1'b0, a, d});
    endtask
    task automatic run(input logic [7:0] msk, input logic f);
        int i;
        note_wr(sec_pkg::UNLOCK_A1, sec_pkg::UNLOCK_D1);
        note_wr(sec_pkg::UNLOCK_A2, sec_pkg::UNLOCK_D2);
        note_wr(sec_pkg::UNLOCK_A1, sec_pkg::ERASE_SETUP);
        note_wr(sec_pkg::UNLOCK_A1, sec_pkg::UNLOCK_D1);
        note_wr(sec_pkg::UNLOCK_A2, sec_pkg::UNLOCK_D2);
        for (i = 0; i < 8; i++) if (msk[i]) note_wr({i[2:0], 14'h0000}, sec_pkg::SECTOR_ERASE);
        if (f) begin
            note_wr(sec_pkg::UNLOCK_A1, sec_pkg::UNLOCK_D1);
            note_wr(sec_pkg::UNLOCK_A2, sec_pkg::UNLOCK_D2);
            note_wr(sec_pkg::UNLOCK_A1, sec_pkg::RESET_CMD);
        end
        res_q.push_back({!f, f, f ? last_ok : (msk & ~PROT)});
        if (!f) last_ok = msk & ~PROT;
        @(posedge clk);
        // the closing read runs after the done pulse, so wait for idle
        while (busy_ff !== 1'b0) @(posedge clk);
        fail_mode <= f;
        go <= 1'b1;
        sector_mask <= msk;
        @(posedge clk);
        go <= 1'b0;
        sector_mask <= 8'($random(seed));
        repeat (1000) @(posedge clk);
        check({busy_ff, window_closed_ff}, 2'b10);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        i = 0;
        while (result_ff.done !== 1'b1 && i < 20000) begin
            @(posedge clk);
            i++;
        end
        @(posedge clk);
    endtask
    // writes are compared when the strobe first goes low, verdicts on done
    always @(negedge clk) begin
        if (we_last && !we_b) check({ce_b, addr, dq_out}, wr_q.size() ? wr_q.pop_front() : '1);
        if (result_ff.done === 1'b1) begin
            check({result_ff.ok, result_ff.failed, erased}, res_q.size() ? res_q.pop_front() : '1);
            check(window_closed_ff, 1'b1);
        end
        we_last = we_b;
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        check({ce_b, we_b, oe_b, dq_oe, busy_ff}, 5'b11100);
        run(8'h01, 1'b0);
        run(8'h80, 1'b0);
        run(8'hFF, 1'b0);
        run(8'h24, 1'b1);
        run(PROT, 1'b0);
        repeat (3) begin
            m = 8'($random(seed));
            run(m == 8'h00 ? 8'h5A : m, 1'b0);
        end
        @(posedge clk);
        while (busy_ff !== 1'b0) @(posedge clk);
        go <= 1'b1;
        sector_mask <= 8'h00;
        @(posedge clk);
        go <= 1'b0;
        repeat (20) @(posedge clk);
        check({busy_ff, we_b, wr_q.size() != 0, res_q.size() != 0}, 4'b0100);
        print_verdict;
    end
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        print_verdict;
    end
endmodule
`default_nettype wire
